/* rtl/srd_consts.svh */
// Constants for the scan result and direct conversion register block.
// Assumes inclusion by bare name from the package and design files.
`ifndef SRD_CONSTS_SVH
`define SRD_CONSTS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define SRD_PACK_LOW_OFS 8'ha6
`define SRD_PACK_HIGH_OFS 8'ha7
`define SRD_REGU_LOW_OFS 8'ha8
`define SRD_REGU_HIGH_OFS 8'ha9
`define SRD_DIRECT_LOW_OFS 8'haa
`define SRD_DIRECT_HIGH_OFS 8'hab
// Host controller register offsets on its user port
`define SRD_HC_CTRL_OFS 8'h00
`define SRD_HC_STATUS_OFS 8'h01
`define SRD_HC_PACK_OFS 8'h02
`define SRD_HC_REGU_OFS 8'h03
`define SRD_HC_DIRECT_OFS 8'h04

// ----------------------------------------------------------------------
// Field layout and reset values
// ----------------------------------------------------------------------
`define SRD_SCAN_W 12
`define SRD_DIRECT_W 14
`define SRD_HIGH_SCAN_W 4
`define SRD_HIGH_DIRECT_W 6
`define SRD_MUX_W 4
`define SRD_RESULT_RST 12'h000
`define SRD_PACK_DIVIDER 32
`define SRD_REGU_DIVIDER 2
`define SRD_FULL_CODE 4095
// Host control word bits
`define SRD_CTRL_TAKEOVER_BIT 4
`define SRD_CTRL_START_BIT 5

`endif

/* rtl/srd_device.sv */
// Device end: scan result and direct conversion result registers.
// Assumes scan and converter results arrive from same-clock logic.
`timescale 1ns/10ps
`include "srd_consts.svh"

module srd_device (
    srd_if.device bus,
    input wire logic scan_done,
    input wire logic [11:0] pack_voltage_result,
    input wire logic [11:0] regulator_voltage_result,
    input wire logic conv_done,
    input wire logic [13:0] direct_conversion_result,
    output logic conv_request,
    output logic [3:0] conv_channel
);
    // ------------------------------------------------------------------
    // Result storage
    // ------------------------------------------------------------------
    srd_pkg::srd_scan_t pack_q;
    srd_pkg::srd_scan_t regu_q;
    srd_pkg::srd_direct_t direct_q;
    logic start_q;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;

    // Whole words are latched at once, but byte reads are not held, so a scan between low and high reads mixes them
    always_ff @(posedge bus.clk or negedge bus.rst_n) begin
        if (!bus.rst_n) begin
            pack_q <= `SRD_RESULT_RST;
            regu_q <= `SRD_RESULT_RST;
        end else if (scan_done) begin
            pack_q <= pack_voltage_result;
            regu_q <= regulator_voltage_result;
        end
    end

    always_ff @(posedge bus.clk or negedge bus.rst_n) begin
        if (!bus.rst_n) begin
            direct_q <= 14'h0000;
        end else if (conv_done) begin
            direct_q <= direct_conversion_result;
        end
    end

    // ------------------------------------------------------------------
    // Conversion trigger
    // ------------------------------------------------------------------
    // Start only honoured under takeover; a rising edge makes one request
    always_ff @(posedge bus.clk or negedge bus.rst_n) begin
        if (!bus.rst_n) begin
            start_q <= 1'b0;
        end else begin
            start_q <= bus.conversion_start_bit;
        end
    end

    assign conv_request = bus.takeover && bus.conversion_start_bit
        && !start_q;
    assign conv_channel = bus.mux_channel_select;

    // ------------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------------
    always_comb begin
        rdata_d = 8'h00;
        case (bus.addr)
            `SRD_PACK_LOW_OFS: rdata_d = pack_q[7:0];
            `SRD_PACK_HIGH_OFS: rdata_d = {4'h0, pack_q[11:8]};
            `SRD_REGU_LOW_OFS: rdata_d = regu_q[7:0];
            `SRD_REGU_HIGH_OFS: rdata_d = {4'h0, regu_q[11:8]};
            `SRD_DIRECT_LOW_OFS: rdata_d = direct_q[7:0];
            `SRD_DIRECT_HIGH_OFS: rdata_d = {2'h0, direct_q[13:8]};
            default: rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge bus.clk or negedge bus.rst_n) begin
        if (!bus.rst_n) begin
            rdata_q <= 8'h00;
        end else if (bus.rd) begin
            rdata_q <= rdata_d;
        end
    end

    assign bus.rdata = rdata_q;
endmodule // srd_device

/* rtl/srd_host.sv */
// Host end: reads scan results, runs direct conversions under takeover.
// Assumes device answers reads one cycle after the read strobe.
`timescale 1ns/10ps
`include "srd_consts.svh"

module srd_host (
    srd_if.host bus,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata
);
    // ------------------------------------------------------------------
    // Control and fetch state
    // ------------------------------------------------------------------
    srd_pkg::srd_host_state_t state_q;
    logic takeover_q;
    logic [3:0] chan_q;
    logic start_q;
    logic busy_q;
    logic [7:0] base_q;
    logic [7:0] low_q;
    logic [1:0] which_q;
    logic [11:0] pack_q;
    logic [11:0] regu_q;
    logic [13:0] direct_q;
    logic [3:0] wait_q;
    logic [7:0] rdata_q;

    // Ctrl write: bit4 takeover, bit5 start, 3:0 channel
    always_ff @(posedge bus.clk or negedge bus.rst_n) begin
        if (!bus.rst_n) begin
            takeover_q <= 1'b0;
            chan_q <= 4'h0;
        end else if (wr && addr == `SRD_HC_CTRL_OFS) begin
            takeover_q <= wdata[`SRD_CTRL_TAKEOVER_BIT];
            chan_q <= wdata[3:0];
        end
    end

    // Start pulses at the head of the wait, after takeover and channel
    // settle, so the converter result is stored before the fetch reads it
    always_ff @(posedge bus.clk or negedge bus.rst_n) begin
        if (!bus.rst_n) begin
            start_q <= 1'b0;
        end else begin
            start_q <= state_q == srd_pkg::SRD_WAIT_CONV
                && wait_q == 4'h3;
        end
    end

    // Status write reads pack then regulator result in turn; start bit runs a direct read alone
    always_ff @(posedge bus.clk or negedge bus.rst_n) begin
        if (!bus.rst_n) begin
            state_q <= srd_pkg::SRD_IDLE;
            busy_q <= 1'b0;
            base_q <= 8'h00;
            low_q <= 8'h00;
            which_q <= 2'd0;
            wait_q <= 4'h0;
            pack_q <= 12'h000;
            regu_q <= 12'h000;
            direct_q <= 14'h0000;
        end else begin
            case (state_q)
                srd_pkg::SRD_IDLE: begin
                    busy_q <= 1'b0;
                    if (wr && addr == `SRD_HC_CTRL_OFS
                        && wdata[`SRD_CTRL_START_BIT] && takeover_q) begin
                        busy_q <= 1'b1;
                        wait_q <= 4'h3;
                        state_q <= srd_pkg::SRD_WAIT_CONV;
                    end else if (wr && addr == `SRD_HC_STATUS_OFS) begin
                        busy_q <= 1'b1;
                        which_q <= 2'd0;
                        base_q <= `SRD_PACK_LOW_OFS;
                        state_q <= srd_pkg::SRD_READ_LOW;
                    end
                end
                srd_pkg::SRD_WAIT_CONV: begin
                    wait_q <= wait_q - 4'h1;
                    if (wait_q == 4'h0) begin
                        which_q <= 2'd2;
                        base_q <= `SRD_DIRECT_LOW_OFS;
                        state_q <= srd_pkg::SRD_READ_LOW;
                    end
                end
                srd_pkg::SRD_READ_LOW: begin
                    state_q <= srd_pkg::SRD_READ_HIGH;
                end
                srd_pkg::SRD_READ_HIGH: begin
                    low_q <= bus.rdata;
                    state_q <= srd_pkg::SRD_DONE;
                end
                srd_pkg::SRD_DONE: begin
                    if (which_q == 2'd0) begin
                        pack_q <= {bus.rdata[3:0], low_q};
                        which_q <= 2'd1;
                        base_q <= `SRD_REGU_LOW_OFS;
                        state_q <= srd_pkg::SRD_READ_LOW;
                    end else if (which_q == 2'd1) begin
                        regu_q <= {bus.rdata[3:0], low_q};
                        state_q <= srd_pkg::SRD_IDLE;
                    end else begin
                        direct_q <= {bus.rdata[5:0], low_q};
                        state_q <= srd_pkg::SRD_IDLE;
                    end
                end
                default: state_q <= srd_pkg::SRD_IDLE;
            endcase
        end
    end

    assign bus.rd = state_q == srd_pkg::SRD_READ_LOW
        || state_q == srd_pkg::SRD_READ_HIGH;
    assign bus.addr = state_q == srd_pkg::SRD_READ_HIGH
        ? base_q + 8'h01 : base_q;
    assign bus.takeover = takeover_q;
    assign bus.mux_channel_select = chan_q;
    assign bus.conversion_start_bit = start_q;

    // ------------------------------------------------------------------
    // User read port
    // ------------------------------------------------------------------
    always_ff @(posedge bus.clk or negedge bus.rst_n) begin
        if (!bus.rst_n) begin
            rdata_q <= 8'h00;
        end else if (rd) begin
            case (addr)
                `SRD_HC_CTRL_OFS: rdata_q <= {2'h0, 1'b0, takeover_q, chan_q};
                `SRD_HC_STATUS_OFS: rdata_q <= {7'h00, busy_q};
                `SRD_HC_PACK_OFS: rdata_q <= pack_q[11:4];
                `SRD_HC_REGU_OFS: rdata_q <= regu_q[11:4];
                `SRD_HC_DIRECT_OFS: rdata_q <= direct_q[13:6];
                default: rdata_q <= 8'h00;
            endcase
        end
    end

    assign rdata = rdata_q;
endmodule // srd_host

/* rtl/srd_if.sv */
// Register link between the device result block and the host.
// Assumes one clock shared by both ends; read data one cycle late.
`timescale 1ns/10ps

interface srd_if (
    input wire logic clk,
    input wire logic rst_n
);
    logic [7:0] addr;
    logic rd;
    logic [7:0] rdata;
    logic takeover;
    logic [3:0] mux_channel_select;
    logic conversion_start_bit;
    modport device (
        input clk, rst_n, addr, rd, takeover, mux_channel_select,
        input conversion_start_bit,
        output rdata
    );
    modport host (
        input clk, rst_n, rdata,
        output addr, rd, takeover, mux_channel_select, conversion_start_bit
    );
endinterface

/* rtl/srd_pkg.sv */
// Types shared by both ends of the scan result register link.
// Assumes srd_consts.svh is on the include path.
`include "srd_consts.svh"

package srd_pkg;
    typedef logic [7:0] srd_byte_t;
    typedef logic [`SRD_SCAN_W-1:0] srd_scan_t;
    typedef logic signed [`SRD_DIRECT_W-1:0] srd_direct_t;
    typedef enum logic [4:0] {
        SRD_IDLE = 5'b00001,
        SRD_READ_LOW = 5'b00010,
        SRD_READ_HIGH = 5'b00100,
        SRD_WAIT_CONV = 5'b01000,
        SRD_DONE = 5'b10000
    } srd_host_state_t;
endpackage

/* test/srd_assertions.sv */
// Checker for the register link between host and device ends.
// Assumes it sees the interface signals as plain inputs, one clock.
`timescale 1ns/10ps

module srd_assertions (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] addr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    input wire logic takeover,
    input wire logic [3:0] mux_channel_select,
    input wire logic conversion_start_bit
);
    default clocking dc @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_PACK_HIGH_RSV: assert property (rd && addr == 8'ha7 |=>
        rdata[7:4] == 4'h0) else $error("pack high byte reserved set");
    AST_REGU_HIGH_RSV: assert property (rd && addr == 8'ha9 |=>
        rdata[7:4] == 4'h0) else $error("regulator reserved set");
    AST_DIRECT_HIGH_RSV: assert property (rd && addr == 8'hab |=>
        rdata[7:6] == 2'b00) else $error("direct reserved set");
    AST_RDATA_STANDS: assert property (!rd |=> $stable(rdata))
        else $error("read data moved without a read");
    AST_START_NEEDS_TAKEOVER: assert property (conversion_start_bit
        |-> takeover) else $error("start without takeover");
    AST_CHANNEL_SET_FIRST: assert property (conversion_start_bit
        |-> $stable(mux_channel_select)) else $error("channel moved at start");
    AST_DIRECT_AFTER_START: assert property (conversion_start_bit
        |-> ##[1:10] (rd && addr == 8'haa)) else $error("no direct fetch");
    AST_DIRECT_PAIR: assert property (rd && addr == 8'haa
        |-> ##[1:2] (rd && addr == 8'hab)) else $error("direct high missed");
    AST_PACK_PAIR: assert property (rd && addr == 8'ha6
        |-> ##[1:3] (rd && addr == 8'ha7)) else $error("pack high missed");

    cover property (conversion_start_bit);
    cover property (rd && addr == 8'ha9);
    cover property (rd && addr == 8'hab);
endmodule // srd_assertions

/* test/tb_top.sv */
// Testbench joining host and device ends through the register link.
// Assumes the host user port answers reads one cycle after the strobe.
`timescale 1ns/10ps

module tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic scan_done = 1'b0;
    logic conv_done = 1'b0;
    logic [11:0] pack_v = 12'h000, regu_v = 12'h000;
    logic [11:0] pack_exp = 12'h000, regu_exp = 12'h000;
    logic [13:0] dir_v = 14'h0000, dir_exp = 14'h0000;
    logic conv_request;
    logic [3:0] conv_channel;
    logic rd_d = 1'b0;
    logic [7:0] a_d = 8'h00;
    int bad_count = 0;
    int comparisons = 0;
    int reqs = 0;

    always #10 clk = ~clk;

    srd_if i_srd_if (.clk(clk), .rst_n(rst_n));
    srd_device i_srd_device (.bus(i_srd_if.device), .scan_done(scan_done),
        .pack_voltage_result(pack_v), .regulator_voltage_result(regu_v),
        .conv_done(conv_done), .direct_conversion_result(dir_v),
        .conv_request(conv_request), .conv_channel(conv_channel));
    srd_host i_srd_host (.bus(i_srd_if.host), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata));
    srd_assertions i_srd_assertions (.clk(clk), .rst_n(rst_n),
        .addr(i_srd_if.addr), .rd(i_srd_if.rd), .rdata(i_srd_if.rdata),
        .takeover(i_srd_if.takeover),
        .mux_channel_select(i_srd_if.mux_channel_select),
        .conversion_start_bit(i_srd_if.conversion_start_bit));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h want %h", $time, seen, exp);
        end
    endtask

    // Converter stand-in: answers each request one cycle later
    always @(posedge clk) begin
        conv_done <= conv_request;
        if (conv_request === 1'b1) begin
            dir_exp <= dir_v;
            reqs <= reqs + 1;
        end
        rd_d <= i_srd_if.rd;
        a_d <= i_srd_if.addr;
    end

    // Wire monitor: read data judged mid-cycle, after it has settled
    always @(negedge clk) begin
        if (rd_d === 1'b1) begin
            case (a_d)
                8'ha6: check(i_srd_if.rdata, pack_exp[7:0]);
                8'ha7: check(i_srd_if.rdata, pack_exp[11:8]);
                8'ha8: check(i_srd_if.rdata, regu_exp[7:0]);
                8'ha9: check(i_srd_if.rdata, regu_exp[11:8]);
                8'haa: check(i_srd_if.rdata, dir_exp[7:0]);
                8'hab: check(i_srd_if.rdata, dir_exp[13:8]);
                default: ;
            endcase
        end
    end

    task automatic hwr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic hrd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask

    task automatic wait_idle();
        logic [7:0] s;
        for (int i = 0; i < 40; i++) begin
            hrd(8'h01, s);
            if (s[0] === 1'b0) return;
        end
        bad_count++;
        final_report();
    endtask

    task automatic t_scan(input logic [11:0] p, input logic [11:0] r);
        logic [7:0] d;
        @(posedge clk);
        pack_v <= p;
        regu_v <= r;
        scan_done <= 1'b1;
        @(posedge clk);
        scan_done <= 1'b0;
        pack_exp = p;
        regu_exp = r;
        // Inputs move without a scan: stored results must not follow
        pack_v <= ~p;
        regu_v <= ~r;
        hwr(8'h01, 8'h00);
        wait_idle();
        hrd(8'h02, d);
        check(d, p[11:4]);
        hrd(8'h03, d);
        check(d, r[11:4]);
    endtask

    task automatic t_direct(input logic [13:0] v, input logic [3:0] ch);
        logic [7:0] d;
        int n;
        n = reqs;
        hwr(8'h00, {4'h1, ch});
        dir_v <= v;
        hwr(8'h00, {4'h3, ch});
        wait_idle();
        check(conv_channel, ch);
        check(16'(reqs - n), 16'h0001);
        hrd(8'h04, d);
        check(d, v[13:6]);
    endtask

    task automatic t_refuse();
        logic [7:0] d;
        int n;
        n = reqs;
        hwr(8'h00, 8'h05);
        hwr(8'h00, 8'h25);
        repeat (8) @(posedge clk);
        check(16'(reqs - n), 16'h0000);
        hrd(8'h00, d);
        check(d, 8'h05);
        hrd(8'h07, d);
        check(d, 8'h00);
    endtask

    task automatic final_report();
        if (bad_count == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        t_scan(12'habc, 12'h5a3);
        t_scan(12'hfff, 12'h001);
        t_direct(14'h2abc, 4'h3);
        t_direct(14'h1fff, 4'hc);
        t_refuse();
        final_report();
    end
endmodule // tb_top
